// file: shared/dcsr_pkg.sv
// Constants and carrier types for the dual channel serial readout.
// Assumes a 200 MHz system clock; link pins are synchronised in the core.
package dcsr_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int WORD_BITS = 16;
	localparam int FRAME_BITS = 32;
	localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
	localparam logic [5:0] WORD_BITS_CNT = 6'h10;

	// ----------------------------------------
	// Timing and reset values
	// ----------------------------------------
	localparam int CLK_SYS_MHZ = 200;
	localparam int SCLK_BASE_NS = 20;
	localparam int SCLK_HALF_CYC = (SCLK_BASE_NS * CLK_SYS_MHZ) / 2000;
	localparam logic [7:0] SCLK_HALF_CNT = 8'(SCLK_HALF_CYC);
	localparam logic [5:0] BITCNT_RST = 6'h00;
	localparam logic [31:0] SHIFT_RST = 32'h0000_0000;
	localparam logic [1:0] SYNC_RST = 2'h3;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic clockSourceSelect;
		logic portTypeSelect;
		logic channelOrderA;
		logic invertSclk;
		logic invertSync;
		logic [1:0] clockDividerSelect;
	} dcsr_cfg_type;

	typedef struct packed {
		logic [15:0] chanA;
		logic [15:0] chanB;
	} dcsr_result_type;

	typedef enum logic [1:0] {
		M_IDLE,
		M_SHIFT,
		M_GAP
	} dcsr_mstate_type;

endpackage

// file: hdl/dcsr_serial_port.sv
// Serial result output port: master and slave readout of two 16-bit words.
// Assumes results arrive from the converter core on clk_sys with strobes;
// link pins (sclk, cs, rd, chain) come from outside and are synchronised.
//
// Function
// - Low source select: device makes serial clock
// - Master drives frame strobe; both polarities invertible
// - Master data changes on the falling clock edge, stable at the rising edge
// - Read-mode pin picks after/during conversion output
// - Master after-conversion: busy held until 32 bits
// - Divider inputs slow master clock after conversion
// - Master during-conversion: strobe drops after each LSB
// - High source select: external clock used
// - Slave clock gated; data only when selected
// - Slave after-conversion: 32 bits MSB first
// - Slave after-conversion: chain input follows data
// - Chain sampled opposite edge to shifting
// - Slave during-conversion: previous result, 32 bits
// - Slave during-conversion: incomplete read at conversion end pulses error
// - Serial port used when port select high
// - Order select: A first high, B low
// - Channel A word updated after B done
// - Outputs released when select or read high
`timescale 1ns/1ps

module dcsr_serial_port
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire dcsr_pkg::dcsr_cfg_type cfg,
	input wire logic convBusyCore,
	input wire logic convDone,
	input wire logic chanBDone,
	input wire dcsr_pkg::dcsr_result_type result,
	input wire logic sclkIn,
	input wire logic csN,
	input wire logic rdN,
	input wire logic read_mode_or_chain_in,
	output logic sclkOut,
	output logic sclkOutEnN,
	output logic syncOut,
	output logic serial_data_out,
	output logic serialDataEnN,
	output logic busy,
	output logic read_overrun_pulse
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [3:0] syncA_ff, syncB_ff;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA_ff <= {dcsr_pkg::SYNC_RST, 2'h0};
			syncB_ff <= {dcsr_pkg::SYNC_RST, 2'h0};
		end
		else if (clkEn)
		begin
			syncA_ff <= {csN, rdN, sclkIn, read_mode_or_chain_in};
			syncB_ff <= syncA_ff;
		end
	end
	logic csS, rdS, sclkS, chainS, sclkPrev_ff;
	assign {csS, rdS, sclkS, chainS} = syncB_ff;

	logic master, duringMode, selected, rise, fall;
	assign master = ~cfg.clockSourceSelect;
	assign duringMode = chainS;
	assign selected = cfg.portTypeSelect & ~csS & ~rdS;
	// Slave clock edges only count while selected; stray edges are ignored
	assign rise = selected & sclkS & ~sclkPrev_ff;
	assign fall = selected & ~sclkS & sclkPrev_ff;

	// ----------------------------------------
	// Result latch
	// ----------------------------------------
	// Channel A is parked here and joins a frame only when B is done
	logic [15:0] pendA_ff;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pendA_ff <= 16'h0000;
		else if (clkEn && convDone)
			pendA_ff <= result.chanA;
	end

	// Built from the arriving B word, so the load costs no extra cycle
	logic [31:0] frame;
	assign frame = cfg.channelOrderA ? {pendA_ff, result.chanB}
		: {result.chanB, pendA_ff};

	// ----------------------------------------
	// Shifter
	// ----------------------------------------
	dcsr_pkg::dcsr_mstate_type mState_ff;
	logic [31:0] shift_ff;
	logic [5:0] bitCnt_ff;
	logic [7:0] divCnt_ff;
	logic [7:0] halfLen;
	logic sclkInt_ff, syncInt_ff, pending_ff, holdBusy_ff, mTick;
	assign halfLen = 8'(dcsr_pkg::SCLK_HALF_CNT << cfg.clockDividerSelect);
	assign mTick = (divCnt_ff == 8'h00);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sclkPrev_ff <= 1'b0;
		else if (clkEn)
			sclkPrev_ff <= sclkS;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			divCnt_ff <= 8'h00;
		else if (clkEn)
			divCnt_ff <= (mTick || mState_ff == dcsr_pkg::M_IDLE)
				? halfLen - 8'h01 : divCnt_ff - 8'h01;
	end

	// Frame pending: set by a new result, cleared when all 32 bits go out
	logic frameDone;
	assign frameDone = (bitCnt_ff == dcsr_pkg::FRAME_BITS_CNT);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pending_ff <= 1'b0;
		else if (clkEn)
		begin
			if (chanBDone) // Set wins over clear
				pending_ff <= 1'b1;
			else if (frameDone)
				pending_ff <= 1'b0;
		end
	end

	// Overrun: in slave during mode, a new conversion ends with the previous frame partly read
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			read_overrun_pulse <= 1'b0;
		else if (clkEn)
			read_overrun_pulse <= ~master & duringMode & chanBDone
				& pending_ff & (bitCnt_ff != 6'h00);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mState_ff <= dcsr_pkg::M_IDLE;
			shift_ff <= dcsr_pkg::SHIFT_RST;
			bitCnt_ff <= dcsr_pkg::BITCNT_RST;
			sclkInt_ff <= 1'b0;
			syncInt_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			// A new result aborts any frame; a finished one keeps its
			// count so later slave edges are refused until the next load
			if (chanBDone)
			begin
				bitCnt_ff <= dcsr_pkg::BITCNT_RST;
				shift_ff <= frame;
				mState_ff <= dcsr_pkg::M_IDLE;
				syncInt_ff <= 1'b0;
				sclkInt_ff <= 1'b0;
			end
			else if (master)
			begin
				case (mState_ff)
				dcsr_pkg::M_IDLE:
					// Start once a frame waits; during mode waits for busy
					if (pending_ff && cfg.portTypeSelect
						&& (!duringMode || convBusyCore))
					begin
						mState_ff <= dcsr_pkg::M_SHIFT;
						syncInt_ff <= 1'b1;
					end
				dcsr_pkg::M_SHIFT:
					if (mTick)
					begin
						sclkInt_ff <= ~sclkInt_ff;
						// Shift on the falling edge so data is stable
						// around the rising edge and a full period wide
						if (sclkInt_ff)
						begin
							shift_ff <= {shift_ff[30:0], 1'b0};
							bitCnt_ff <= bitCnt_ff + 6'h01;
							if (bitCnt_ff[3:0] == 4'hF)
							begin
								syncInt_ff <= 1'b0;
								mState_ff <= dcsr_pkg::M_GAP;
							end
						end
					end
				dcsr_pkg::M_GAP:
					if (frameDone)
						mState_ff <= dcsr_pkg::M_IDLE;
					else if (mTick)
					begin
						syncInt_ff <= 1'b1;
						mState_ff <= dcsr_pkg::M_SHIFT;
					end
				default:
					mState_ff <= dcsr_pkg::M_IDLE;
				endcase
			end
			else
			begin
				mState_ff <= dcsr_pkg::M_IDLE;
				if (fall && !frameDone)
				begin
					// Chain input enters behind our own bits
					shift_ff <= {shift_ff[30:0],
						duringMode ? 1'b0 : chainS};
					bitCnt_ff <= bitCnt_ff + 6'h01;
				end
			end
		end
	end

	// Chain bit caught on the rising edge, opposite to the shift edge
	logic chainLatch_ff;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			chainLatch_ff <= 1'b0;
		else if (clkEn && rise)
			chainLatch_ff <= chainS;
	end

	// ----------------------------------------
	// Busy and pins
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			holdBusy_ff <= 1'b0;
		else if (clkEn)
			holdBusy_ff <= master & ~duringMode & pending_ff
				& cfg.portTypeSelect;
	end
	assign busy = convBusyCore | holdBusy_ff;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_data_out <= 1'b0;
			sclkOut <= 1'b0;
			syncOut <= 1'b0;
		end
		else if (clkEn)
		begin
			// After the frame, a chained slave passes upstream data on
			serial_data_out <= (frameDone && !master)
				? chainLatch_ff : shift_ff[31];
			sclkOut <= sclkInt_ff ^ cfg.invertSclk;
			syncOut <= syncInt_ff ^ cfg.invertSync;
		end
	end
	assign serialDataEnN = ~selected;
	assign sclkOutEnN = ~(master & selected);

endmodule

// file: bench/dcsr_monitor.sv
// Checker on the serial port's pins.
// Assumes link pins reach the port two clocks late.
`timescale 1ns/1ps
module dcsr_monitor
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dcsr_pkg::dcsr_cfg_type cfg,
	input wire logic convBusyCore,
	input wire logic chanBDone,
	input wire logic csN,
	input wire logic read_mode_or_chain_in,
	input wire logic sclkOutEnN,
	input wire logic syncOut,
	input wire logic serialDataEnN,
	input wire logic busy,
	input wire logic read_overrun_pulse
);
	// --
	// Checks
	// --
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_busy_core: assert property (convBusyCore |-> busy)
		else $error("busy low in conversion");
	chk_busy_hold: assert property (chanBDone && !cfg.clockSourceSelect
		&& cfg.portTypeSelect && !read_mode_or_chain_in |=> ##1 busy[*8])
		else $error("busy hold missing");
	chk_slave_busy: assert property (cfg.clockSourceSelect[*3]
		##0 !convBusyCore |-> !busy)
		else $error("busy held in slave");
	chk_slave_clock: assert property (cfg.clockSourceSelect |-> sclkOutEnN)
		else $error("clock driven in slave");
	chk_par_quiet: assert property (!cfg.portTypeSelect
		|-> serialDataEnN && sclkOutEnN)
		else $error("serial pins driven");
	chk_deselect_release: assert property (csN[*3] |-> serialDataEnN)
		else $error("data driven unselected");
	chk_ovr_single: assert property (read_overrun_pulse |=> !read_overrun_pulse)
		else $error("overrun too long");
	chk_ovr_cause: assert property ($rose(read_overrun_pulse)
		|-> $past(chanBDone) && cfg.clockSourceSelect)
		else $error("overrun without cause");
	chk_sync_gap: assert property ($fell(syncOut) && !cfg.invertSync
		|-> !syncOut[*2])
		else $error("word gap too short");
endmodule

bind dcsr_serial_port dcsr_monitor u_mon
(
	.clk_sys, .rst_n, .cfg, .convBusyCore, .chanBDone, .csN,
	.read_mode_or_chain_in, .sclkOutEnN, .syncOut, .serialDataEnN,
	.busy, .read_overrun_pulse
);

// file: bench/dcsr_host_model.sv
// Host serial port: selects the port and reads n bits.
// Assumes the data pin and its release enable are visible.
`timescale 1ns/1ps
module dcsr_host_model
(
	input wire logic clk_sys,
	input wire logic sdo,
	input wire logic sdoEnN,
	input wire logic mclk,
	output logic sclk,
	output logic csN,
	output logic rdN,
	output logic [39:0] rx
);
	// --
	// Reads
	// --
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		rdN = 1'b1;
		rx = '0;
	end

	// Released line reads inverted, so stale data cannot pass
	function automatic logic bitIn();
		return sdoEnN ? ~rx[0] : sdo;
	endfunction

	task automatic read(input int n, input bit ext);
		csN <= 1'b0;
		rdN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		repeat (n)
		begin
			if (ext)
			begin
				rx <= {rx[38:0], bitIn()};
				sclk <= 1'b1;
				repeat (8) @(posedge clk_sys);
				sclk <= 1'b0;
				repeat (8) @(posedge clk_sys);
			end
			else
			begin
				@(posedge mclk);
				rx <= {rx[38:0], bitIn()};
			end
		end
		repeat (2) @(posedge clk_sys);
		csN <= 1'b1;
		rdN <= 1'b1;
	endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the serial port.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module testbench;
	`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
		fails++; $display("Error %0t %h %h", $time, a, b); end end
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cbusy = 1'b0;
	logic chanBDone = 1'b0;
	logic aDone = 1'b0;
	logic chain = 1'b0;
	logic ovrSeen = 1'b0;
	logic sclk, csN, rdN, mclk, so, soEnN, busy, ovr;
	logic [39:0] rx;
	dcsr_pkg::dcsr_cfg_type cfg = '0;
	dcsr_pkg::dcsr_result_type res = 32'hA5C3_3C5B;
	int fails = 0;
	int tests_run = 0;
	time t0;

	// --
	// Harness
	// --
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (ovr)
			ovrSeen <= 1'b1;

	dcsr_serial_port u_dut
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .cfg(cfg),
		.convBusyCore(cbusy), .convDone(aDone), .chanBDone(chanBDone),
		.result(res), .sclkIn(sclk), .csN(csN), .rdN(rdN),
		.read_mode_or_chain_in(chain), .sclkOut(mclk), .sclkOutEnN(),
		.syncOut(), .serial_data_out(so), .serialDataEnN(soEnN),
		.busy(busy), .read_overrun_pulse(ovr)
	);
	dcsr_host_model u_host
	(
		.clk_sys(clk_sys), .sdo(so), .sdoEnN(soEnN), .mclk(mclk),
		.sclk(sclk), .csN(csN), .rdN(rdN), .rx(rx)
	);

	task load;
		@(posedge clk_sys);
		aDone <= 1'b1;
		@(posedge clk_sys);
		aDone <= 1'b0;
		chanBDone <= 1'b1;
		@(posedge clk_sys);
		chanBDone <= 1'b0;
	endtask

	task summarize;
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			cfg <= '{1'b0, 1'b1, k == 0, 1'b0, 1'b0, 2'(k)};
			t0 = $time;
			fork
				u_host.read(32, 1'b0);
				begin
					repeat (6) @(posedge clk_sys);
					load();
				end
			join
			`CHK(rx[31:0], k ? {res.chanB, res.chanA} : res)
			`CHK($time - t0 >= (600 << k), 1'b1)
			repeat (20) @(posedge clk_sys);
			`CHK(busy, 1'b0)
			$display("master test %0d done", k);
		end
		cfg <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0};
		chain <= 1'b1;
		load();
		u_host.read(33, 1'b1);
		`CHK(rx[32:0], {res, chain})
		repeat (4) @(posedge clk_sys);
		`CHK(soEnN, 1'b1)
		$display("slave chain test done");
		// Pin held fixed while reading during conversion
		chain <= 1'b1;
		cbusy <= 1'b1;
		load();
		ovrSeen <= 1'b0;
		u_host.read(4, 1'b1);
		load();
		repeat (4) @(posedge clk_sys);
		`CHK(ovrSeen, 1'b1)
		`CHK(rx[3:0], res.chanA[15:12])
		cbusy <= 1'b0;
		$display("overrun test done");
		cfg <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
		fork
			u_host.read(2, 1'b1);
			begin
				repeat (10) @(posedge clk_sys);
				`CHK(soEnN, 1'b1)
			end
		join
		$display("parallel select test done");
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		summarize();
	end
endmodule
